// ==== core/cgrf_mem.sv ====
// Storage of the eight word registers with registered read ports
`timescale 1ns/10ps
module cgrf_mem
   import cgrf_pkg::*;
(
   // Clock
   input wire logic clock_in,
   // Control side
   cgrf_mem_if.mem bus
);

   // ************************************************************
   // Storage
   // ************************************************************
   cgrf_word_type words_q [CGRF_NUM_WORDS];  // Word registers, no reset
   cgrf_word_type sp_d;                      // Next value of register seven

   // Merged next value of word register seven
   assign sp_d = {(bus.wr_idx == CGRF_SP_INDEX && bus.wr_be[1]) ? bus.wr_data[15:8] : words_q[CGRF_SP_INDEX][15:8],
                  (bus.wr_idx == CGRF_SP_INDEX && bus.wr_be[0]) ? bus.wr_data[7:0] : words_q[CGRF_SP_INDEX][7:0]};

   // Lane writes; contents are left alone by reset
   always_ff @(posedge clock_in) begin
      if (bus.wr_be[1]) begin
         words_q[bus.wr_idx][15:8] <= bus.wr_data[15:8];
      end
      if (bus.wr_be[0]) begin
         words_q[bus.wr_idx][7:0] <= bus.wr_data[7:0];
      end
   end

   // Registered port reads see contents before this edge's write; sp_data takes sp_d, which includes it
   always_ff @(posedge clock_in) begin
      bus.rd_a_data <= words_q[bus.rd_a_idx];
      bus.rd_b_data <= words_q[bus.rd_b_idx];
      bus.rd_c_data <= words_q[bus.rd_c_idx];
      bus.sp_data <= sp_d;
   end

endmodule // cgrf_mem

// ==== core/cgrf_top.sv ====
// General register file: eight words, sixteen bytes, stack pointer in word seven
// How it works
// - Sixteen bytes pair into eight shared words
// - Every register serves as operand or address
// - Word access and separate upper/lower byte access
// - Address port always delivers full word
// - Word seven is stack pointer, hardware adjusted
// - Stack pointer holds current top of stack
// - Addresses are 16 bits, 64 kilobytes
// - Reset leaves all register contents unchanged
`timescale 1ns/10ps
module cgrf_top
   import cgrf_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic arst_n_in,
   // Operand read port A
   input wire logic rd_a_en_in,
   input wire cgrf_sel_type rd_a_sel_in,
   input wire logic rd_a_size_in,
   output cgrf_word_type rd_a_data_out,
   output logic rd_a_valid_out,
   // Operand read port B
   input wire logic rd_b_en_in,
   input wire cgrf_sel_type rd_b_sel_in,
   input wire logic rd_b_size_in,
   output cgrf_word_type rd_b_data_out,
   output logic rd_b_valid_out,
   // Address read port
   input wire logic ad_en_in,
   input wire cgrf_idx_type ad_sel_in,
   output cgrf_word_type ad_data_out,
   output logic ad_valid_out,
   // Datapath write port
   input wire logic wr_en_in,
   input wire cgrf_sel_type wr_sel_in,
   input wire logic wr_size_in,
   input wire cgrf_word_type wr_data_in,
   // Stack pointer adjust and view
   input wire logic sp_dec_in,
   input wire logic sp_inc_in,
   output cgrf_word_type sp_out
);

   // ************************************************************
   // Storage instance
   // ************************************************************
   cgrf_mem_if mbus ();  // Storage carrier

   // Eight word registers
   cgrf_mem u_mem (
      .clock_in (clock_in),
      .bus (mbus.mem)
   );

   // ************************************************************
   // Write port selection
   // ************************************************************
   logic sp_op;             // One stack adjust requested
   cgrf_word_type sp_next;  // Adjusted stack pointer
   cgrf_word_type wr_lane;  // Datapath data moved to its lane

   // A push and a pop together cancel out
   assign sp_op = sp_dec_in ^ sp_inc_in;
   // Wraps inside the 16-bit space
   assign sp_next = sp_dec_in ? mbus.sp_data - CGRF_SP_STEP : mbus.sp_data + CGRF_SP_STEP;
   // Byte data sits in the low bits of the write bus
   assign wr_lane = (wr_size_in == CGRF_SIZE_WORD) ? wr_data_in : {wr_data_in[7:0], wr_data_in[7:0]};

   // Stack adjust takes the port ahead of the datapath
   assign mbus.wr_idx = sp_op ? CGRF_SP_INDEX : wr_sel_in[3:1];
   assign mbus.wr_data = sp_op ? sp_next : wr_lane;
   // Byte write enables one lane only
   assign mbus.wr_be = sp_op ? CGRF_BE_BOTH : (wr_en_in ? cgrf_lanes(wr_size_in, wr_sel_in[0]) : CGRF_BE_NONE);

   // ************************************************************
   // Read port addressing
   // ************************************************************
   // Operand ports address any word
   assign mbus.rd_a_idx = rd_a_sel_in[3:1];
   assign mbus.rd_b_idx = rd_b_sel_in[3:1];
   // Address port uses whole word index
   assign mbus.rd_c_idx = ad_sel_in;

   // ************************************************************
   // Read pipeline
   // ************************************************************
   logic a_en_q;       // Port A request in storage stage
   logic a_size_q;     // Port A size in storage stage
   logic a_half_q;     // Port A half in storage stage
   logic b_en_q;       // Port B request in storage stage
   logic b_size_q;     // Port B size in storage stage
   logic b_half_q;     // Port B half in storage stage
   logic ad_en_q;      // Address request in storage stage
   cgrf_word_type a_d;  // Port A selected value
   cgrf_word_type b_d;  // Port B selected value

   // Byte or word extraction
   assign a_d = cgrf_pick(mbus.rd_a_data, a_size_q, a_half_q);
   assign b_d = cgrf_pick(mbus.rd_b_data, b_size_q, b_half_q);

   // Request stage flags
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         a_en_q <= 1'b0;
         a_size_q <= CGRF_SIZE_WORD;
         a_half_q <= 1'b0;
         b_en_q <= 1'b0;
         b_size_q <= CGRF_SIZE_WORD;
         b_half_q <= 1'b0;
         ad_en_q <= 1'b0;
      end else begin
         a_en_q <= rd_a_en_in;
         a_size_q <= rd_a_size_in;
         a_half_q <= rd_a_sel_in[0];
         b_en_q <= rd_b_en_in;
         b_size_q <= rd_b_size_in;
         b_half_q <= rd_b_sel_in[0];
         ad_en_q <= ad_en_in;
      end
   end

   // Output registers, data held between requests
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_a_data_out <= CGRF_WORD_ZERO;
         rd_b_data_out <= CGRF_WORD_ZERO;
         ad_data_out <= CGRF_WORD_ZERO;
         rd_a_valid_out <= 1'b0;
         rd_b_valid_out <= 1'b0;
         ad_valid_out <= 1'b0;
      end else begin
         rd_a_valid_out <= a_en_q;
         rd_b_valid_out <= b_en_q;
         ad_valid_out <= ad_en_q;
         if (a_en_q) begin
            rd_a_data_out <= a_d;
         end
         if (b_en_q) begin
            rd_b_data_out <= b_d;
         end
         if (ad_en_q) begin
            ad_data_out <= mbus.rd_c_data;
         end
      end
   end

   // Current top of stack, straight from storage register
   assign sp_out = mbus.sp_data;

   // ************************************************************
   // Checks
   // ************************************************************
   // Word read of register seven matches stack view
   property p_word_rd;
      @(posedge clock_in) disable iff (!arst_n_in)
      rd_a_en_in && rd_a_size_in && rd_a_sel_in[3:1] == CGRF_SP_INDEX |-> ##2 rd_a_valid_out && rd_a_data_out == $past(sp_out, 2);
   endproperty
   a_word_rd: assert property (p_word_rd) else $error("word read mismatch");

   // Low byte read shares storage with the word
   property p_byte_rd;
      @(posedge clock_in) disable iff (!arst_n_in)
      rd_b_en_in && !rd_b_size_in && rd_b_sel_in == {CGRF_SP_INDEX, 1'b0} |-> ##2 rd_b_data_out == {CGRF_BYTE_ZERO, $past(sp_out[7:0], 2)};
   endproperty
   a_byte_rd: assert property (p_byte_rd) else $error("byte read mismatch");

   // Word written then read back by address port
   property p_wr_rd;
      @(posedge clock_in) disable iff (!arst_n_in)
      (wr_en_in && wr_size_in && !sp_op) ##1 (ad_en_in && ad_sel_in == $past(wr_sel_in[3:1])) |-> ##2 ad_data_out == $past(wr_data_in, 3);
   endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("write readback mismatch");

   // Port A byte reads have a zero upper byte
   property p_byte_upper;
      @(posedge clock_in) disable iff (!arst_n_in)
      a_en_q && !a_size_q |=> rd_a_data_out[15:8] == CGRF_BYTE_ZERO;
   endproperty
   a_byte_upper: assert property (p_byte_upper) else $error("byte read upper not zero");

   // Address port gives the whole word
   property p_addr;
      @(posedge clock_in) disable iff (!arst_n_in)
      ad_en_in && ad_sel_in == CGRF_SP_INDEX |-> ##2 ad_valid_out && ad_data_out == $past(sp_out, 2);
   endproperty
   a_addr: assert property (p_addr) else $error("address word mismatch");

   // Push lowers the stack pointer by one word
   property p_dec;
      @(posedge clock_in) disable iff (!arst_n_in)
      sp_dec_in && !sp_inc_in |=> sp_out == $past(sp_out) - CGRF_SP_STEP;
   endproperty
   a_dec: assert property (p_dec) else $error("stack decrement wrong");

   // Pop raises it, wrapping at 16 bits
   property p_inc;
      @(posedge clock_in) disable iff (!arst_n_in)
      sp_inc_in && !sp_dec_in |=> sp_out == cgrf_word_type'($past(sp_out) + CGRF_SP_STEP);
   endproperty
   a_inc: assert property (p_inc) else $error("stack increment wrong");

   // Stack pointer holds without a write to it
   property p_hold;
      @(posedge clock_in) disable iff (!arst_n_in)
      !sp_op && !(wr_en_in && wr_sel_in[3:1] == CGRF_SP_INDEX) |=> $stable(sp_out);
   endproperty
   a_hold: assert property (p_hold) else $error("stack pointer drifted");

   // Upper byte write keeps the lower half
   property p_keep;
      @(posedge clock_in) disable iff (!arst_n_in)
      wr_en_in && !wr_size_in && !sp_op && wr_sel_in == {CGRF_SP_INDEX, CGRF_HALF_HIGH}
      |=> sp_out[7:0] == $past(sp_out[7:0]) && sp_out[15:8] == $past(wr_data_in[7:0]);
   endproperty
   a_keep: assert property (p_keep) else $error("byte write touched other half");

   // Main scenarios
   property p_cov_push_pop;
      @(posedge clock_in) disable iff (!arst_n_in)
      sp_dec_in && !sp_inc_in ##1 sp_inc_in && !sp_dec_in;
   endproperty
   c_push_pop: cover property (p_cov_push_pop);

   property p_cov_byte_wr;
      @(posedge clock_in) disable iff (!arst_n_in)
      wr_en_in && !wr_size_in && !sp_op;
   endproperty
   c_byte_wr: cover property (p_cov_byte_wr);

   property p_cov_all_ports;
      @(posedge clock_in) disable iff (!arst_n_in)
      rd_a_valid_out && rd_b_valid_out && ad_valid_out;
   endproperty
   c_all_ports: cover property (p_cov_all_ports);

endmodule // cgrf_top

// ==== shared/cgrf_mem_if.sv ====
// Interface between the register file control logic and its storage
`timescale 1ns/10ps
interface cgrf_mem_if;
   import cgrf_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   cgrf_be_type wr_be;        // Byte lanes written this cycle
   cgrf_idx_type wr_idx;      // Word register written
   cgrf_word_type wr_data;    // Write data, lanes in place
   cgrf_idx_type rd_a_idx;    // Operand port A index
   cgrf_idx_type rd_b_idx;    // Operand port B index
   cgrf_idx_type rd_c_idx;    // Address port index
   cgrf_word_type rd_a_data;  // Registered port A word
   cgrf_word_type rd_b_data;  // Registered port B word
   cgrf_word_type rd_c_data;  // Registered address word
   cgrf_word_type sp_data;    // Registered copy of word register seven

   // Storage side
   modport mem (input wr_be, wr_idx, wr_data, rd_a_idx, rd_b_idx, rd_c_idx,
                output rd_a_data, rd_b_data, rd_c_data, sp_data);
   // Control side
   modport ctl (output wr_be, wr_idx, wr_data, rd_a_idx, rd_b_idx, rd_c_idx,
                input rd_a_data, rd_b_data, rd_c_data, sp_data);
endinterface

// ==== shared/cgrf_pkg.sv ====
// Package with the sizes, encodings and helpers of the general register file
package cgrf_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int CGRF_WORD_W = 16;    // Word register width
   localparam int CGRF_BYTE_W = 8;     // Byte register width
   localparam int CGRF_NUM_WORDS = 8;  // Number of word registers
   localparam int CGRF_IDX_W = 3;      // Word register index width
   localparam int CGRF_SEL_W = 4;      // Byte register select width

   // ************************************************************
   // Types
   // ************************************************************
   typedef logic [CGRF_WORD_W-1:0] cgrf_word_type;  // One word register
   typedef logic [CGRF_BYTE_W-1:0] cgrf_byte_type;  // One byte half
   typedef logic [CGRF_IDX_W-1:0] cgrf_idx_type;    // Word index
   typedef logic [CGRF_SEL_W-1:0] cgrf_sel_type;    // {word index, half}
   typedef logic [1:0] cgrf_be_type;                // Byte lane enables

   // ************************************************************
   // Encodings and constants
   // ************************************************************
   localparam logic CGRF_SIZE_WORD = 1'b1;             // Access size word
   localparam logic CGRF_HALF_HIGH = 1'b1;             // Upper byte half
   localparam cgrf_idx_type CGRF_SP_INDEX = 3'h7;      // Word register seven
   localparam cgrf_word_type CGRF_SP_STEP = 16'h0002;  // Stack step of one word
   localparam cgrf_byte_type CGRF_BYTE_ZERO = 8'h00;   // Fill of unused upper byte
   localparam cgrf_word_type CGRF_WORD_ZERO = 16'h0000;  // Output value at reset
   localparam cgrf_be_type CGRF_BE_BOTH = 2'h3;        // Write both lanes
   localparam cgrf_be_type CGRF_BE_HIGH = 2'h2;        // Write upper lane
   localparam cgrf_be_type CGRF_BE_LOW = 2'h1;         // Write lower lane
   localparam cgrf_be_type CGRF_BE_NONE = 2'h0;        // Write nothing

   // ************************************************************
   // Helpers
   // ************************************************************
   // Picks word or one byte half, byte zero-extended
   function automatic cgrf_word_type cgrf_pick(input cgrf_word_type w, input logic size, input logic half);
      cgrf_word_type r;
      r = w;
      if (size != CGRF_SIZE_WORD) begin
         r = (half == CGRF_HALF_HIGH) ? {CGRF_BYTE_ZERO, w[15:8]} : {CGRF_BYTE_ZERO, w[7:0]};
      end
      return r;
   endfunction

   // Lane enables for a write of given size and half
   function automatic cgrf_be_type cgrf_lanes(input logic size, input logic half);
      cgrf_be_type r;
      r = CGRF_BE_BOTH;
      if (size != CGRF_SIZE_WORD) begin
         r = (half == CGRF_HALF_HIGH) ? CGRF_BE_HIGH : CGRF_BE_LOW;
      end
      return r;
   endfunction

endpackage

// ==== testbench/cgrf_dp_model.sv ====
// Datapath model issuing reads, writes and stack adjusts to the register file
`timescale 1ns/10ps
module cgrf_dp_model
   import cgrf_pkg::*;
(
   // Clock
   input wire logic clock_in,
   // Read requests
   output logic rd_a_en_out,
   output cgrf_sel_type rd_a_sel_out,
   output logic rd_a_size_out,
   output logic rd_b_en_out,
   output cgrf_sel_type rd_b_sel_out,
   output logic rd_b_size_out,
   output logic ad_en_out,
   output cgrf_idx_type ad_sel_out,
   // Write and stack requests
   output logic wr_en_out,
   output cgrf_sel_type wr_sel_out,
   output logic wr_size_out,
   output cgrf_word_type wr_data_out,
   output logic sp_dec_out,
   output logic sp_inc_out,
   // Answers
   input wire cgrf_word_type rd_a_data_in,
   input wire logic rd_a_valid_in,
   input wire cgrf_word_type rd_b_data_in,
   input wire logic rd_b_valid_in,
   input wire cgrf_word_type ad_data_in,
   input wire logic ad_valid_in
);
   // ***********************************
   // Idle state and request tasks
   // ***********************************
   // All requests idle from time zero
   initial begin
      {rd_a_en_out, rd_b_en_out, ad_en_out, wr_en_out, sp_dec_out, sp_inc_out} = 6'h00;
      {rd_a_sel_out, rd_b_sel_out, wr_sel_out, ad_sel_out} = 15'h0000;
      {rd_a_size_out, rd_b_size_out, wr_size_out} = 3'h0;
      wr_data_out = 16'h0000;
   end

   // One read on port 0 (A), 1 (B) or 2 (address), answer awaited a bounded time
   task automatic rd(input int port, input cgrf_sel_type sel, input logic size,
                     output cgrf_word_type data, output int lat);
      logic v;
      data = 16'h0000;
      lat = 0;
      @(posedge clock_in);
      rd_a_en_out <= (port == 0);
      rd_b_en_out <= (port == 1);
      ad_en_out <= (port == 2);
      rd_a_sel_out <= sel;
      rd_b_sel_out <= sel;
      ad_sel_out <= sel[3:1];
      rd_a_size_out <= size;
      rd_b_size_out <= size;
      @(posedge clock_in);
      {rd_a_en_out, rd_b_en_out, ad_en_out} <= 3'h0;
      for (int i = 1; i <= 6 && lat == 0; i++) begin
         @(posedge clock_in);
         #1;
         v = (port == 0) ? rd_a_valid_in : (port == 1) ? rd_b_valid_in : ad_valid_in;
         // Take the data in the one cycle the valid stands
         if (v === 1'h1) begin
            lat = i;
            data = (port == 0) ? rd_a_data_in : (port == 1) ? rd_b_data_in : ad_data_in;
         end
      end
   endtask

   // One cycle of write and/or stack adjust, outputs settled on return
   task automatic op(input logic wen, input cgrf_sel_type sel, input logic size,
                     input cgrf_word_type data, input logic dec, input logic inc);
      @(posedge clock_in);
      wr_en_out <= wen;
      wr_sel_out <= sel;
      wr_size_out <= size;
      wr_data_out <= data;
      sp_dec_out <= dec;
      sp_inc_out <= inc;
      @(posedge clock_in);
      {wr_en_out, sp_dec_out, sp_inc_out} <= 3'h0;
      #1;
   endtask

   // Word write in one cycle, address read of that word taken in the next
   task automatic wr_ad(input cgrf_idx_type idx, input cgrf_word_type data,
                        output cgrf_word_type seen, output logic valid);
      @(posedge clock_in);
      wr_en_out <= 1'h1;
      wr_sel_out <= {idx, 1'h0};
      wr_size_out <= CGRF_SIZE_WORD;
      wr_data_out <= data;
      @(posedge clock_in);
      // Write taken at this edge, read request follows straight after
      wr_en_out <= 1'h0;
      ad_en_out <= 1'h1;
      ad_sel_out <= idx;
      @(posedge clock_in);
      ad_en_out <= 1'h0;
      @(posedge clock_in);
      #1;
      // Answer stands in this cycle only
      seen = ad_data_in;
      valid = ad_valid_in;
   endtask
endmodule // cgrf_dp_model

// ==== testbench/cpu_general_register_file_test.sv ====
// Self-checking testbench of the general register file
`timescale 1ns/10ps
module cpu_general_register_file_test
   import cgrf_pkg::*;
;
   // ***********************************
   // Signals, clock, design and model
   // ***********************************
   logic clock_in, arst_n_in, rd_a_en_in, rd_b_en_in, ad_en_in, wr_en_in, sp_dec_in, sp_inc_in;
   logic rd_a_size_in, rd_b_size_in, wr_size_in, rd_a_valid_out, rd_b_valid_out, ad_valid_out;
   cgrf_sel_type rd_a_sel_in, rd_b_sel_in, wr_sel_in;
   cgrf_idx_type ad_sel_in;
   cgrf_word_type wr_data_in, rd_a_data_out, rd_b_data_out, ad_data_out, sp_out;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;

   // Free-running clock, 4 ns period
   initial begin
      clock_in = 1'h0;
      forever #2 clock_in = ~clock_in;
   end

   cgrf_top uut (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .rd_a_en_in(rd_a_en_in), .rd_a_sel_in(rd_a_sel_in), .rd_a_size_in(rd_a_size_in),
      .rd_a_data_out(rd_a_data_out), .rd_a_valid_out(rd_a_valid_out),
      .rd_b_en_in(rd_b_en_in), .rd_b_sel_in(rd_b_sel_in), .rd_b_size_in(rd_b_size_in),
      .rd_b_data_out(rd_b_data_out), .rd_b_valid_out(rd_b_valid_out),
      .ad_en_in(ad_en_in), .ad_sel_in(ad_sel_in), .ad_data_out(ad_data_out), .ad_valid_out(ad_valid_out),
      .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in), .wr_size_in(wr_size_in), .wr_data_in(wr_data_in),
      .sp_dec_in(sp_dec_in), .sp_inc_in(sp_inc_in), .sp_out(sp_out));

   cgrf_dp_model dp (.clock_in(clock_in),
      .rd_a_en_out(rd_a_en_in), .rd_a_sel_out(rd_a_sel_in), .rd_a_size_out(rd_a_size_in),
      .rd_b_en_out(rd_b_en_in), .rd_b_sel_out(rd_b_sel_in), .rd_b_size_out(rd_b_size_in),
      .ad_en_out(ad_en_in), .ad_sel_out(ad_sel_in), .wr_en_out(wr_en_in), .wr_sel_out(wr_sel_in),
      .wr_size_out(wr_size_in), .wr_data_out(wr_data_in), .sp_dec_out(sp_dec_in), .sp_inc_out(sp_inc_in),
      .rd_a_data_in(rd_a_data_out), .rd_a_valid_in(rd_a_valid_out), .rd_b_data_in(rd_b_data_out),
      .rd_b_valid_in(rd_b_valid_out), .ad_data_in(ad_data_out), .ad_valid_in(ad_valid_out));

   // ***********************************
   // Checking and closing
   // ***********************************
   // Compares one value and counts it
   task automatic check(input string what, input cgrf_word_type seen, input cgrf_word_type exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run
   task automatic print_verdict();
      $display("Checks made: %0d, mismatches: %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         print_verdict();
      end
   end

   // Distinct word pattern per register
   function automatic cgrf_word_type pat(input int n);
      return 16'hF00F ^ (16'(n) * 16'h1111);
   endfunction

   // ***********************************
   // Scenarios
   // ***********************************
   // Word writes, then word reads of every register on all three ports
   task automatic t_words();
      cgrf_word_type d;
      int lat;
      for (int n = 0; n < CGRF_NUM_WORDS; n++) begin
         dp.op(1'h1, {n[2:0], 1'h0}, CGRF_SIZE_WORD, pat(n), 1'h0, 1'h0);
      end
      check("stack pointer view", sp_out, pat(7));
      for (int n = 0; n < CGRF_NUM_WORDS; n++) begin
         for (int p = 0; p < 3; p++) begin
            dp.rd(p, {n[2:0], 1'h1}, CGRF_SIZE_WORD, d, lat);
            check("word read", d, pat(n));
            check("read latency", 16'(lat), 16'h0001);
         end
      end
   endtask

   // Byte writes keep the other half, byte reads come zero-extended
   task automatic t_bytes();
      cgrf_word_type d;
      cgrf_word_type p;
      int lat;
      for (int n = 0; n < CGRF_NUM_WORDS; n++) begin
         p = pat(n);
         dp.op(1'h1, {n[2:0], 1'h1}, 1'h0, 16'hEE00 | 16'(8'hC3 ^ n[7:0]), 1'h0, 1'h0);
         dp.rd(0, {n[2:0], 1'h0}, CGRF_SIZE_WORD, d, lat);
         check("after upper write", d, {8'hC3 ^ n[7:0], p[7:0]});
         dp.op(1'h1, {n[2:0], 1'h0}, 1'h0, 16'h7700 | 16'(8'h5A ^ n[7:0]), 1'h0, 1'h0);
         dp.rd(1, {n[2:0], 1'h0}, CGRF_SIZE_WORD, d, lat);
         check("after lower write", d, {8'hC3 ^ n[7:0], 8'h5A ^ n[7:0]});
         dp.rd(0, {n[2:0], 1'h1}, 1'h0, d, lat);
         check("upper byte read", d, {8'h00, 8'hC3 ^ n[7:0]});
         dp.rd(1, {n[2:0], 1'h0}, 1'h0, d, lat);
         check("lower byte read", d, {8'h00, 8'h5A ^ n[7:0]});
      end
   endtask

   // Word write, then an address read one cycle later sees the new word
   task automatic t_wr_ad();
      cgrf_word_type d;
      logic v;
      dp.wr_ad(3'h2, 16'hA5C3, d, v);
      check("address read after write", d, 16'hA5C3);
      check("address read valid", {15'h0000, v}, 16'h0001);
   endtask

   // Push, pop, wrap, and the stack op against a datapath write
   task automatic t_stack();
      cgrf_word_type d;
      int lat;
      dp.op(1'h1, 4'h6, CGRF_SIZE_WORD, 16'h5555, 1'h0, 1'h0);
      dp.op(1'h1, 4'hE, CGRF_SIZE_WORD, 16'h0100, 1'h0, 1'h0);
      check("stack pointer load", sp_out, 16'h0100);
      dp.op(1'h0, 4'h0, 1'h0, 16'h0000, 1'h1, 1'h0);
      dp.op(1'h0, 4'h0, 1'h0, 16'h0000, 1'h1, 1'h0);
      check("two pushes", sp_out, 16'h00FC);
      dp.op(1'h0, 4'h0, 1'h0, 16'h0000, 1'h0, 1'h1);
      check("one pop", sp_out, 16'h00FE);
      dp.rd(2, 4'hE, CGRF_SIZE_WORD, d, lat);
      check("stack pointer as address", d, 16'h00FE);
      dp.op(1'h1, 4'h6, CGRF_SIZE_WORD, 16'hDEAD, 1'h1, 1'h0);
      dp.rd(0, 4'h6, CGRF_SIZE_WORD, d, lat);
      check("write dropped by push", d, 16'h5555);
      check("push beside dropped write", sp_out, 16'h00FC);
      dp.op(1'h1, 4'h6, CGRF_SIZE_WORD, 16'hBEEF, 1'h1, 1'h1);
      dp.rd(1, 4'h6, CGRF_SIZE_WORD, d, lat);
      check("write with cancelled adjust", d, 16'hBEEF);
      check("cancelled adjust", sp_out, 16'h00FC);
      dp.op(1'h1, 4'hE, CGRF_SIZE_WORD, 16'h0000, 1'h0, 1'h0);
      dp.op(1'h0, 4'h0, 1'h0, 16'h0000, 1'h1, 1'h0);
      check("push wraps", sp_out, 16'hFFFE);
      dp.op(1'h0, 4'h0, 1'h0, 16'h0000, 1'h0, 1'h1);
      check("pop wraps", sp_out, 16'h0000);
   endtask

   // Reset in mid-run clears outputs but leaves the register contents
   task automatic t_reset();
      cgrf_word_type d;
      int lat;
      @(posedge clock_in);
      arst_n_in <= 1'h0;
      repeat (2) @(posedge clock_in);
      #1;
      check("port A data in reset", rd_a_data_out, CGRF_WORD_ZERO);
      check("address data in reset", ad_data_out, CGRF_WORD_ZERO);
      check("valids in reset", {13'h0000, rd_a_valid_out, rd_b_valid_out, ad_valid_out}, 16'h0000);
      @(posedge clock_in);
      arst_n_in <= 1'h1;
      dp.rd(0, 4'h6, CGRF_SIZE_WORD, d, lat);
      check("contents kept over reset", d, 16'hBEEF);
      check("stack pointer kept over reset", sp_out, 16'h0000);
   endtask

   // Main sequence
   initial begin
      arst_n_in = 1'h0;
      repeat (5) @(posedge clock_in);
      arst_n_in <= 1'h1;
      t_words();
      t_bytes();
      t_wr_ad();
      t_stack();
      t_reset();
      print_verdict();
   end
endmodule // cpu_general_register_file_test
